// *** src/btg_branch_cfg.svh ***
`ifndef BTG_BRANCH_CFG_SVH
`define BTG_BRANCH_CFG_SVH

// instruction word layout
`define INSTR_W 16
`define OPC_HI 15
`define OPC_LO 12
`define OPC_TOGGLE 4'h7
`define BR_HI 15
`define BR_LO 8
`define BR_OVERFLOW 8'hE4
`define BR_ZERO 8'hE0
`define BIT_HI 11
`define BIT_LO 9
`define ACC_BIT 8
`define LOW_HI 7
`define LOW_LO 0

// data memory addressing
`define BANK_W 4
`define FREG_W 8
`define DADDR_W 12
`define ACC_SPLIT_BIT 7
`define ACC_LOW_BANK 4'h0
`define ACC_HIGH_BANK 4'hF

// program counter
`define PC_W 21
`define PC_RESET 21'h000000

`endif

// *** src/btg_branch_pkg.sv ***
`include "btg_branch_cfg.svh"

package btg_branch_pkg;

    // quarter of the instruction cycle
    typedef enum logic [1:0] {
        QTR_1,
        QTR_2,
        QTR_3,
        QTR_4
    } quarter_t;

    // instruction held for execution
    typedef enum logic [1:0] {
        OP_NONE,
        OP_TOGGLE,
        OP_BR_OVERFLOW,
        OP_BR_ZERO
    } op_t;

    // quarter generator state
    typedef struct packed {
        quarter_t qtr;
    } qgen_state_t;

    // execution state
    typedef struct packed {
        logic [1:0] rst_sync;
        op_t op;
        logic [2:0] bit_sel;
        logic taken;
        logic flush;
        logic [`PC_W-1:0] pc_next;
        logic [`INSTR_W-1:0] low_byte;
        logic mem_rd_en;
        logic mem_wr_en;
        logic [`DADDR_W-1:0] mem_addr;
        logic [`FREG_W-1:0] mem_wr_data;
        logic pc_load;
        logic [`PC_W-1:0] pc_target;
        logic busy;
    } exec_state_t;

endpackage

// *** src/quarter_if.sv ***
`timescale 1ns/100ps

// quarter phase carried from generator to executor
interface quarter_if;
    logic rst_sync_n;
    btg_branch_pkg::quarter_t qtr;

    modport gen (
        input rst_sync_n,
        output qtr
    );

    modport use_side (
        output rst_sync_n,
        input qtr
    );
endinterface

// *** src/quarter_gen.sv ***
`timescale 1ns/100ps
`include "btg_branch_cfg.svh"

// steps Q1..Q4, one quarter per clock
module quarter_gen (
    input wire logic clk,
    quarter_if.gen qi
);

    btg_branch_pkg::qgen_state_t s_q;
    btg_branch_pkg::qgen_state_t s_d;

    // next quarter, wrapping after Q4
    always_comb begin
        s_d = s_q;
        case (s_q.qtr)
            btg_branch_pkg::QTR_1: s_d.qtr = btg_branch_pkg::QTR_2;
            btg_branch_pkg::QTR_2: s_d.qtr = btg_branch_pkg::QTR_3;
            btg_branch_pkg::QTR_3: s_d.qtr = btg_branch_pkg::QTR_4;
            default: s_d.qtr = btg_branch_pkg::QTR_1;
        endcase
    end

    // quarter register
    always_ff @(posedge clk or negedge qi.rst_sync_n) begin
        if (!qi.rst_sync_n) begin
            s_q <= '{qtr: btg_branch_pkg::QTR_1};
        end else begin
            s_q <= s_d;
        end
    end

    assign qi.qtr = s_q.qtr;

endmodule

// *** src/bit_toggle_and_flag_branch_exec.sv ***
`timescale 1ns/100ps
`include "btg_branch_cfg.svh"

// What this block does
// - decode toggle word: 0111, bit, access, register
// - invert only chosen bit, flags untouched
// - access bit 0 access bank, 1 bank register
// - decode overflow branch: upper byte 1110 0100
// - overflow set: pc = next + 2n
// - decode zero branch: upper byte 1110 0000
// - zero set: pc = next + 2n
// - overflow branch one cycle, two when taken
// - zero branch one cycle, two when taken
module bit_toggle_and_flag_branch_exec (
    // clock and raw reset
    input wire logic clk,
    input wire logic rst_n,
    // instruction and core state in
    input wire logic instr_valid,
    input wire logic [`INSTR_W-1:0] instr_word,
    input wire logic [`PC_W-1:0] pc_incremented,
    input wire logic overflow_flag,
    input wire logic zero_flag,
    input wire logic [`BANK_W-1:0] bank_select_reg,
    // data memory read path
    input wire logic [`FREG_W-1:0] mem_rd_data,
    // sequencing and memory and pc requests out
    output logic [1:0] quarter,
    output logic instr_accept,
    output logic mem_rd_en,
    output logic mem_wr_en,
    output logic [`DADDR_W-1:0] mem_addr,
    output logic [`FREG_W-1:0] mem_wr_data,
    output logic pc_load,
    output logic [`PC_W-1:0] pc_target,
    output logic flush_cycle,
    output logic busy
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // data address from access bit, bank register and file field
    function automatic logic [`DADDR_W-1:0] data_address(
        input logic access_bit,
        input logic [`BANK_W-1:0] bank,
        input logic [`FREG_W-1:0] freg
    );
        logic [`BANK_W-1:0] b;
        b = bank;
        // access bank: low half from bank 0, high half from the last bank
        if (!access_bit) begin
            b = freg[`ACC_SPLIT_BIT] ? `ACC_HIGH_BANK : `ACC_LOW_BANK;
        end
        return {b, freg};
    endfunction

    // next address plus twice the signed offset
    function automatic logic [`PC_W-1:0] branch_target(
        input logic [`PC_W-1:0] pc_next,
        input logic [`FREG_W-1:0] offset
    );
        logic [`PC_W-1:0] disp;
        // sign copies, the offset, then a zero for the word shift
        disp = {{(`PC_W-`FREG_W-1){offset[`FREG_W-1]}}, offset, 1'b0};
        return pc_next + disp;
    endfunction

    // true for either of the two conditional branches
    function automatic logic is_branch_op(
        input btg_branch_pkg::op_t kind
    );
        return kind == btg_branch_pkg::OP_BR_OVERFLOW || kind == btg_branch_pkg::OP_BR_ZERO;
    endfunction

    // one-hot mask for the selected bit of a data byte
    function automatic logic [`FREG_W-1:0] bit_mask(
        input logic [2:0] sel
    );
        return `FREG_W'(1) << sel;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // quarter sequencing

    quarter_if qi ();

    quarter_gen u_quarter_gen (
        .clk(clk),
        .qi(qi)
    );

    // executor state and its next value
    btg_branch_pkg::exec_state_t s_q;
    btg_branch_pkg::exec_state_t s_d;

    ////////////////////////////////////////////////////////////////////////
    // reset release

    // quarters start only once the two-flop copy of reset is high
    assign qi.rst_sync_n = s_q.rst_sync[1];

    ////////////////////////////////////////////////////////////////////////
    // execution

    logic take_new;
    logic is_toggle;
    logic is_bov;
    logic is_bz;

    // instruction taken only in Q1 of a non-flush cycle, once the quarters run
    assign take_new = instr_valid && qi.rst_sync_n && (qi.qtr == btg_branch_pkg::QTR_1) && !s_q.flush;

    // opcode matches on the raw word
    assign is_toggle = instr_word[`OPC_HI:`OPC_LO] == `OPC_TOGGLE;
    assign is_bov = instr_word[`BR_HI:`BR_LO] == `BR_OVERFLOW;
    assign is_bz = instr_word[`BR_HI:`BR_LO] == `BR_ZERO;

    // Q1 decode and latch operands, Q2 memory read and target sum,
    // Q3 data processed, Q4 write and pc load show on the outputs;
    // flags are taken at decode so a later update cannot steer the branch
    always_comb begin
        s_d = s_q;
        s_d.rst_sync = {s_q.rst_sync[0], 1'b1};
        s_d.mem_rd_en = 1'b0;
        s_d.mem_wr_en = 1'b0;
        s_d.pc_load = 1'b0;
        case (qi.qtr)
            btg_branch_pkg::QTR_1: begin
                // decode; a flush cycle performs nothing
                s_d.op = btg_branch_pkg::OP_NONE;
                s_d.busy = s_q.flush;
                if (take_new) begin
                    // operands latched for every accepted word
                    s_d.bit_sel = instr_word[`BIT_HI:`BIT_LO];
                    s_d.low_byte = {{(`INSTR_W-`FREG_W){1'b0}}, instr_word[`LOW_HI:`LOW_LO]};
                    s_d.pc_next = pc_incremented;
                    s_d.taken = 1'b0;
                    if (is_toggle) begin
                        s_d.op = btg_branch_pkg::OP_TOGGLE;
                        s_d.busy = 1'b1;
                        s_d.mem_rd_en = 1'b1;
                        s_d.mem_addr = data_address(instr_word[`ACC_BIT], bank_select_reg,
                                                    instr_word[`LOW_HI:`LOW_LO]);
                    end else if (is_bov) begin
                        s_d.op = btg_branch_pkg::OP_BR_OVERFLOW;
                        s_d.busy = 1'b1;
                        s_d.taken = overflow_flag;
                    end else if (is_bz) begin
                        s_d.op = btg_branch_pkg::OP_BR_ZERO;
                        s_d.busy = 1'b1;
                        s_d.taken = zero_flag;
                    end
                end
            end
            btg_branch_pkg::QTR_2: begin
                // read of register or literal is in flight
                s_d.pc_target = branch_target(s_q.pc_next, s_q.low_byte[`FREG_W-1:0]);
            end
            btg_branch_pkg::QTR_3: begin
                // process data; write and pc load appear in Q4
                if (s_q.op == btg_branch_pkg::OP_TOGGLE) begin
                    s_d.mem_wr_en = 1'b1;
                    s_d.mem_wr_data = mem_rd_data ^ bit_mask(s_q.bit_sel);
                end
                if (is_branch_op(s_q.op) && s_q.taken) begin
                    s_d.pc_load = 1'b1;
                end
            end
            default: begin
                // a taken branch is followed by one idle cycle
                s_d.flush = is_branch_op(s_q.op) && s_q.taken;
                s_d.busy = s_d.flush;
            end
        endcase
    end

    // state register, async reset to constants only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{
                rst_sync: '0,
                op: btg_branch_pkg::OP_NONE,
                bit_sel: '0,
                taken: 1'b0,
                flush: 1'b0,
                pc_next: `PC_RESET,
                low_byte: '0,
                mem_rd_en: 1'b0,
                mem_wr_en: 1'b0,
                mem_addr: '0,
                mem_wr_data: '0,
                pc_load: 1'b0,
                pc_target: `PC_RESET,
                busy: 1'b0
            };
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // quarter and acceptance
    assign quarter = qi.qtr;
    assign instr_accept = take_new;

    // data memory requests
    assign mem_rd_en = s_q.mem_rd_en;
    assign mem_wr_en = s_q.mem_wr_en;
    assign mem_addr = s_q.mem_addr;
    assign mem_wr_data = s_q.mem_wr_data;

    // program counter requests
    assign pc_load = s_q.pc_load;
    assign pc_target = s_q.pc_target;

    // cycle status
    assign flush_cycle = s_q.flush;
    assign busy = s_q.busy;

endmodule

// *** verif/data_mem_model.sv ***
`timescale 1ns/100ps
// data memory beside the core: one clock read latency
module data_mem_model (
    input wire logic clk,
    input wire logic rd_en,
    input wire logic wr_en,
    input wire logic [11:0] addr,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data
);
    logic [7:0] mem [4096];
    // seed contents so every byte differs from its neighbour
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = i[7:0] ^ 8'hA5;
        end
        rd_data = 8'h00;
    end
    // read data holds one clock only, then scrambles
    always @(posedge clk) begin
        rd_data <= rd_en ? mem[addr] : ~rd_data;
        if (wr_en) begin
            mem[addr] <= wr_data;
        end
    end
endmodule

// *** verif/exec_assertions.sv ***
`timescale 1ns/100ps
// port-level checks of the toggle and branch executor
module exec_assertions (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] instr_word,
    input wire logic instr_accept,
    input wire logic overflow_flag,
    input wire logic zero_flag,
    input wire logic [3:0] bank_select_reg,
    input wire logic [20:0] pc_incremented,
    input wire logic [7:0] mem_rd_data,
    input wire logic [1:0] quarter,
    input wire logic mem_rd_en,
    input wire logic mem_wr_en,
    input wire logic [11:0] mem_addr,
    input wire logic [7:0] mem_wr_data,
    input wire logic pc_load,
    input wire logic [20:0] pc_target,
    input wire logic flush_cycle,
    input wire logic busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // accepted opcode classes
    wire tog = instr_accept && instr_word[15:12] == 4'h7;
    wire ovf = instr_accept && instr_word[15:8] == 8'hE4;
    wire zer = instr_accept && instr_word[15:8] == 8'hE0;
    ////////////////////////////////////////////////////////////
    AST_TOG_CYCLE: assert property (tog |=> mem_rd_en ##2 mem_wr_en)
        else $error("toggle read or write missing");
    AST_TOG_ONE_BIT: assert property (mem_wr_en |-> $countones(mem_wr_data ^ $past(mem_rd_data)) == 1)
        else $error("toggle changed other than one bit");
    AST_ACC_BANK: assert property (tog && !instr_word[8] |=>
        mem_addr == {($past(instr_word[7]) ? 4'hF : 4'h0), $past(instr_word[7:0])}) else $error("access bank address");
    AST_BANK_REG: assert property (tog && instr_word[8] |=>
        mem_addr == {$past(bank_select_reg), $past(instr_word[7:0])}) else $error("bank register address");
    AST_OVF_TAKEN: assert property (ovf && overflow_flag |-> ##3 pc_load ##1 flush_cycle[*4])
        else $error("overflow branch not taken in time");
    AST_ZERO_TAKEN: assert property (zer && zero_flag |-> ##3 pc_load ##1 flush_cycle[*4])
        else $error("zero branch not taken in time");
    AST_NOT_TAKEN: assert property ((ovf && !overflow_flag) || (zer && !zero_flag) |=>
        (!pc_load && !flush_cycle)[*4]) else $error("untaken branch loaded pc");
    AST_TARGET: assert property (pc_load |-> pc_target == $past(pc_incremented, 3) +
        {{12{$past(instr_word[7], 3)}}, $past(instr_word[7:0], 3), 1'b0}) else $error("branch target wrong");
    AST_FLUSH_REFUSE: assert property (flush_cycle && quarter == 2'h0 |-> !instr_accept)
        else $error("word accepted in flush cycle");
    AST_BUSY_ONE: assert property (tog || (ovf && !overflow_flag) || (zer && !zero_flag) |=>
        busy[*3] ##1 !busy) else $error("busy span wrong for one-cycle op");
    AST_BUSY_TAKEN: assert property ((ovf && overflow_flag) || (zer && zero_flag) |=>
        busy[*7] ##1 !busy) else $error("busy span wrong for taken branch");
endmodule

bind bit_toggle_and_flag_branch_exec exec_assertions chk (.clk, .rst_n, .instr_word, .instr_accept,
    .overflow_flag, .zero_flag, .bank_select_reg, .pc_incremented, .mem_rd_data, .quarter, .mem_rd_en,
    .mem_wr_en, .mem_addr, .mem_wr_data, .pc_load, .pc_target, .flush_cycle, .busy);

// *** verif/tb.sv ***
`timescale 1ns/100ps
module tb;
    logic clk, rst_n, instr_valid, overflow_flag, zero_flag, instr_accept, mem_rd_en, mem_wr_en, pc_load, flush_cycle;
    logic [15:0] instr_word;
    logic [20:0] pc_incremented, pc_target;
    logic [3:0] bank_select_reg;
    logic [7:0] mem_rd_data, mem_wr_data;
    logic [11:0] mem_addr;
    logic [1:0] quarter;
    logic [31:0] seed = 32'h0000E1BC;
    logic [31:0] r;
    int mismatches, num_checks;

    bit_toggle_and_flag_branch_exec dut (.clk, .rst_n, .instr_valid, .instr_word, .pc_incremented,
        .overflow_flag, .zero_flag, .bank_select_reg, .mem_rd_data, .quarter, .instr_accept, .mem_rd_en,
        .mem_wr_en, .mem_addr, .mem_wr_data, .pc_load, .pc_target, .flush_cycle, .busy());
    data_mem_model mdl (.clk, .rd_en(mem_rd_en), .wr_en(mem_wr_en), .addr(mem_addr), .wr_data(mem_wr_data),
        .rd_data(mem_rd_data));
    ////////////////////////////////////////////////////////////
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // expected data address and branch target
    function logic [11:0] exp_addr(logic [15:0] w, logic [3:0] b);
        return w[8] ? {b, w[7:0]} : {(w[7] ? 4'hF : 4'h0), w[7:0]};
    endfunction
    function logic [20:0] exp_target(logic [20:0] p, logic [7:0] n);
        return p + {{12{n[7]}}, n, 1'b0};
    endfunction
    task bad(input string m);
        mismatches++;
        $display("BAD %0t %s", $time, m);
    endtask
    task conclude();
        if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one instruction: offer in Q1, wait for accept, check at Q4
    task automatic run(input logic [15:0] w, input logic v, input logic z);
        logic [20:0] p;
        logic [3:0] b;
        logic [7:0] old;
        logic ld, tk;
        int i;
        p = 21'(rnd() << 1);
        b = 4'(rnd());
        tk = (w[15:8] == 8'hE4 && v) || (w[15:8] == 8'hE0 && z);
        while (quarter !== 2'h3) @(negedge clk);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_word <= w;
        overflow_flag <= v;
        zero_flag <= z;
        pc_incremented <= p;
        bank_select_reg <= b;
        i = 0;
        @(negedge clk);
        while (instr_accept !== 1'b1 && i < 20) begin
            @(negedge clk);
            i++;
        end
        if (i == 20) bad("word never accepted");
        old = mdl.mem[exp_addr(w, b)];
        @(posedge clk);
        instr_valid <= 1'b0;
        overflow_flag <= ~v;
        zero_flag <= ~z;
        pc_incremented <= ~p;
        bank_select_reg <= ~b;
        ld = 1'b0;
        repeat (3) begin
            @(negedge clk);
            ld = ld | pc_load;
        end
        num_checks++;
        if (ld !== tk) bad("branch decision");
        num_checks++;
        if (tk && pc_target !== exp_target(p, w[7:0])) bad("branch target");
        num_checks++;
        if (w[15:12] == 4'h7 && mem_wr_data !== (old ^ (8'h01 << w[11:9]))) bad("toggle data");
    endtask
    ////////////////////////////////////////////////////////////
    // free-running core clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // watchdog against a stalled handshake
    initial begin
        #200000;
        mismatches++;
        conclude();
    end
    // reset, corner cases, then random traffic
    initial begin
        rst_n = 1'b0;
        instr_valid = 1'b0;
        instr_word = 16'h0000;
        overflow_flag = 1'b0;
        zero_flag = 1'b0;
        pc_incremented = 21'h000000;
        bank_select_reg = 4'h0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        run(16'hE47F, 1'b1, 1'b0);
        run(16'hE080, 1'b0, 1'b1);
        run(16'hE480, 1'b0, 1'b1);
        run(16'h7EFF, 1'b1, 1'b1);
        run(16'h7100, 1'b0, 1'b0);
        repeat (300) begin
            r = rnd();
            run(r[1] ? (r[0] ? {8'hE0, r[23:16]} : {8'hE4, r[23:16]}) : {(r[0] ? 4'h1 : 4'h7), r[27:16]},
                r[2], r[3]);
        end
        conclude();
    end
endmodule
